// file: common/rss_pkg.sv
// package: constants, register map and states of the rail sequencer supervisor
package rss_pkg;
    localparam int CLK_MHZ = 50;
    localparam int NCH = 5;
    localparam int CW = 24;
    // times as specified
    localparam int T_STEP_NS = 10_000;
    localparam int T_TMO_SHORT_NS = 10_000;
    localparam int T_TMO_LONG_MS = 128;
    localparam int T_FAULT_NS = 1_900;
    localparam int T_MIN_PW_NS = 1_000;
    // cycle counts, least times rounded up
    localparam logic [CW-1:0] STEP_CYC = CW'((T_STEP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CW-1:0] TMO_SHORT_CYC = CW'((T_TMO_SHORT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CW-1:0] TMO_LONG_CYC = CW'(T_TMO_LONG_MS * CLK_MHZ * 1000);
    localparam logic [7:0] FAULT_CYC = 8'((T_FAULT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] MIN_PW_CYC = 8'((T_MIN_PW_NS * CLK_MHZ + 999) / 1000);
    // register map, byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STEP = 12'h004;
    localparam logic [11:0] ADDR_TMO = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00C;
    // control fields
    localparam int CTRL_FIVE = 0;
    localparam int CTRL_TMO_LSB = 1;
    localparam int CTRL_DLY = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [1:0] TMO_FIXED = 2'h1;
    localparam logic [1:0] TMO_PROG = 2'h2;
    // status fields
    localparam int STS_STATE_LSB = 0;
    localparam int STS_EN_LSB = 6;
    localparam int STS_RSTN = 11;
    localparam int STS_FAULT = 12;
    localparam int STS_SAFE = 13;
    localparam int STS_STEP_LSB = 14;
    localparam int STS_GOOD_LSB = 17;
    // tri-level select pin codes equal the ternary digit; 2'h3 reads as digit 0
    localparam logic [1:0] SEL_HIGH = 2'h2;
    localparam logic [1:0] SEL_BAD = 2'h3;
    // synchroniser reset: hold, request and fault idle high
    localparam int SYW = 21;
    localparam logic [SYW-1:0] SYNC_RST = 21'h1C0000;
    typedef enum logic [5:0] {
        S_READY = 6'h01,
        S_UP_WAIT = 6'h02,
        S_UP_DELAY = 6'h04,
        S_RUN = 6'h08,
        S_DOWN_REV = 6'h10,
        S_DOWN_ALL = 6'h20
    } rss_state_t;
endpackage

// file: logic/rss_sequencer.sv
// rail sequencer supervisor: input sync, sequencing machine, reset timer, apb registers
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module rss_sequencer
    import rss_pkg::*;
#(
    parameter logic [CW-1:0] RST_LONG_CYC = TMO_LONG_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparators and control pins, asynchronous
    input wire logic internal_supply_ok,
    input wire logic enable_in,
    input wire logic power_down_req_n,
    input wire logic chain_hold_n,
    input wire logic [1:0] order_sel_a,
    input wire logic [1:0] order_sel_b,
    input wire logic [1:0] order_sel_c,
    input wire logic [NCH-1:0] rail_good,
    input wire logic [NCH-1:0] rail_drain_sense,
    // wired fault line, open drain
    input wire logic fault_line_in,
    output logic fault_line_out,
    output logic fault_line_oe,
    // supply gates, pulldowns and processor reset
    output logic [NCH-1:0] rail_enable,
    output logic [NCH-1:0] rail_discharge,
    output logic proc_reset_n,
    output logic unplug_safe
);

    logic [SYW-1:0] sy1_reg;
    logic [SYW-1:0] sy2_reg;
    logic hold_n_s, pdr_n_s, fault_s, supply_s, en_s;
    logic [1:0] sel_a_s, sel_b_s, sel_c_s;
    logic [NCH-1:0] good_s, drain_s, good_m, drain_m;
    logic [2:0] lo_raw;
    logic [2:0] filt;
    logic five, pd_req, en_loss, ext_fault, start_ok, rail_drop, rst_hold, quiet;
    logic [3:0] ctrl_reg;
    logic [CW-1:0] step_cyc_reg, tmo_cyc_reg, dly_cnt_reg, rst_cnt_reg, dly_len, tmo_len;
    rss_state_t state_reg;
    logic [2:0] step_reg, last_step, cur_ch, nxt_ch, prv_ch;
    logic [14:0] ord_reg, ord_sel;
    logic [7:0] perm;
    logic [4:0] sel_code;
    logic [NCH-1:0] en_reg;
    logic [7:0] fault_cnt_reg;
    logic [31:0] rd_data, sts;
    logic reg_hit, apb_setup, apb_wr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // two-flop synchroniser; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_reg <= SYNC_RST;
            sy2_reg <= SYNC_RST;
        end else begin
            sy1_reg <= {chain_hold_n, power_down_req_n, fault_line_in, internal_supply_ok,
                        enable_in, order_sel_a, order_sel_b, order_sel_c, rail_good,
                        rail_drain_sense};
            sy2_reg <= sy1_reg;
        end
    end

    assign {hold_n_s, pdr_n_s, fault_s, supply_s, en_s, sel_a_s, sel_b_s, sel_c_s,
            good_s, drain_s} = sy2_reg;

    // in four-channel mode the fifth channel is always good and always drained
    assign five = ctrl_reg[CTRL_FIVE];
    assign good_m = good_s | (five ? 5'h00 : 5'h10);
    assign drain_m = drain_s & (five ? 5'h1F : 5'h0F);

    // low-width filters for request, enable loss and fault line
    assign lo_raw = {~fault_s, ~en_s, ~pdr_n_s};
    for (genvar i = 0; i < 3; i++) begin : g_flt
        logic [7:0] cnt_reg;
        logic hit_reg;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg <= 8'h00;
                hit_reg <= 1'b0;
            end else if (!lo_raw[i]) begin
                cnt_reg <= 8'h00;
                hit_reg <= 1'b0;
            end else if (cnt_reg == MIN_PW_CYC) begin
                hit_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
        assign filt[i] = hit_reg;
    end

    // chain hold low masks request and enable loss from the sequencing machine, not the fault line; rst_hold uses filt unmasked
    assign pd_req = filt[0] & hold_n_s;
    assign en_loss = filt[1] & hold_n_s;
    assign ext_fault = filt[2];
    assign start_ok = supply_s && en_s && pdr_n_s && drain_m == 5'h00 && !ext_fault;
    assign rail_drop = state_reg == S_RUN && good_m != 5'h1F && en_s && pdr_n_s;
    assign quiet = supply_s && !pd_req && !en_loss && !ext_fault;

    // order selection
    function automatic logic [1:0] tri_digit(input logic [1:0] pin);
        return (pin == SEL_BAD) ? 2'h0 : pin;
    endfunction

    function automatic logic [7:0] perm_of(input logic [4:0] idx);
        logic [3:0] used;
        logic [7:0] res;
        logic [4:0] r;
        logic [4:0] w;
        logic [1:0] k;
        logic hit;
        used = 4'h0;
        res = 8'h00;
        r = idx;
        for (int p = 0; p < 4; p++) begin
            w = (p == 0) ? 5'h06 : (p == 1) ? 5'h02 : 5'h01;
            k = 2'(r / w);
            r = r % w;
            hit = 1'b0;
            for (int c = 0; c < 4; c++) begin
                if (!used[c] && !hit) begin
                    if (k == 2'h0) begin
                        used[c] = 1'b1;
                        res[p*2 +: 2] = 2'(c);
                        hit = 1'b1;
                    end else begin
                        k = k - 2'h1;
                    end
                end
            end
        end
        return res;
    endfunction

    always_comb begin
        if (sel_a_s == SEL_HIGH && sel_b_s == SEL_HIGH) begin
            sel_code = 5'h00;
        end else begin
            sel_code = 5'(tri_digit(sel_a_s) * 9 + tri_digit(sel_b_s) * 3
                          + tri_digit(sel_c_s));
        end
    end

    assign perm = perm_of(sel_code);
    assign ord_sel = five ? 15'h4688 : {3'h4, 1'b0, perm[7:6], 1'b0, perm[5:4],
                                        1'b0, perm[3:2], 1'b0, perm[1:0]};
    assign last_step = five ? 3'h4 : 3'h3;
    assign cur_ch = ord_reg[3*step_reg +: 3];
    assign nxt_ch = ord_reg[3*(step_reg+3'h1) +: 3];
    assign prv_ch = ord_reg[3*(step_reg-3'h1) +: 3];
    assign dly_len = ctrl_reg[CTRL_DLY] ? step_cyc_reg : STEP_CYC;

    // sequencing machine; lockout and faults override every state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_READY;
            en_reg <= 5'h00;
            step_reg <= 3'h0;
            ord_reg <= 15'h0000;
            dly_cnt_reg <= 24'h000000;
        end else if (!supply_s) begin
            state_reg <= S_READY;
            en_reg <= 5'h00;
        end else if (rail_drop || ext_fault) begin
            state_reg <= S_DOWN_ALL;
            en_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                S_READY: begin
                    if (start_ok) begin
                        ord_reg <= ord_sel;
                        step_reg <= 3'h0;
                        en_reg[ord_sel[2:0]] <= 1'b1;
                        state_reg <= S_UP_WAIT;
                    end
                end
                S_UP_WAIT, S_UP_DELAY, S_RUN: begin
                    if (pd_req) begin
                        en_reg[cur_ch] <= 1'b0;
                        state_reg <= S_DOWN_REV;
                    end else if (en_loss) begin
                        en_reg <= 5'h00;
                        state_reg <= S_DOWN_ALL;
                    end else if (state_reg == S_UP_WAIT) begin
                        // no timeout: a rail that never rises parks here
                        if (good_m[cur_ch]) begin
                            dly_cnt_reg <= 24'h000000;
                            state_reg <= (step_reg == last_step) ? S_RUN : S_UP_DELAY;
                        end
                    end else if (state_reg == S_UP_DELAY) begin
                        if (dly_cnt_reg + 24'h000001 >= dly_len) begin
                            step_reg <= step_reg + 3'h1;
                            en_reg[nxt_ch] <= 1'b1;
                            state_reg <= S_UP_WAIT;
                        end else begin
                            dly_cnt_reg <= dly_cnt_reg + 24'h000001;
                        end
                    end
                end
                S_DOWN_REV: begin
                    // enable is not looked at here, so a late enable drop is ignored
                    if (!drain_m[cur_ch]) begin
                        if (step_reg == 3'h0) begin
                            state_reg <= S_READY;
                        end else begin
                            step_reg <= step_reg - 3'h1;
                            en_reg[prv_ch] <= 1'b0;
                        end
                    end
                end
                S_DOWN_ALL: begin
                    if (drain_m == 5'h00) begin
                        state_reg <= S_READY;
                    end
                end
            endcase
        end
    end

    // gate and pulldown outputs change together, so they never overlap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rail_enable <= 5'h00;
            rail_discharge <= 5'h1F;
            unplug_safe <= 1'b0;
        end else begin
            rail_enable <= en_reg;
            rail_discharge <= ~en_reg;
            unplug_safe <= drain_m == 5'h00;
        end
    end

    // fault line pulse; released in lockout since its level is undefined there
    assign fault_line_out = 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_cnt_reg <= 8'h00;
            fault_line_oe <= 1'b0;
        end else if (!supply_s) begin
            fault_cnt_reg <= 8'h00;
            fault_line_oe <= 1'b0;
        end else if (rail_drop) begin
            fault_cnt_reg <= FAULT_CYC;
            fault_line_oe <= 1'b1;
        end else if (fault_cnt_reg != 8'h00) begin
            fault_cnt_reg <= fault_cnt_reg - 8'h01;
            fault_line_oe <= fault_cnt_reg != 8'h01;
        end
    end

    // reset timer
    always_comb begin
        unique case (ctrl_reg[CTRL_TMO_LSB +: 2])
            TMO_FIXED: tmo_len = RST_LONG_CYC;
            TMO_PROG: tmo_len = tmo_cyc_reg;
            default: tmo_len = TMO_SHORT_CYC;
        endcase
    end

    assign rst_hold = !supply_s || state_reg != S_RUN || good_m != 5'h1F || filt != 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_reg <= 24'h000000;
            proc_reset_n <= 1'b0;
        end else if (rst_hold) begin
            rst_cnt_reg <= 24'h000000;
            proc_reset_n <= 1'b0;
        end else if (rst_cnt_reg + 24'h000001 >= tmo_len) begin
            proc_reset_n <= 1'b1;
        end else begin
            rst_cnt_reg <= rst_cnt_reg + 24'h000001;
        end
    end

    // apb slave: answers in the first access cycle, no wait states
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite && pready;

    always_comb begin
        sts = 32'h00000000;
        sts[STS_STATE_LSB +: 6] = state_reg;
        sts[STS_EN_LSB +: 5] = en_reg;
        sts[STS_RSTN] = proc_reset_n;
        sts[STS_FAULT] = fault_line_oe;
        sts[STS_SAFE] = unplug_safe;
        sts[STS_STEP_LSB +: 3] = step_reg;
        sts[STS_GOOD_LSB +: 5] = good_m;
    end

    always_comb begin
        reg_hit = 1'b1;
        unique case (paddr)
            ADDR_CTRL: rd_data = {28'h0000000, ctrl_reg};
            ADDR_STEP: rd_data = {8'h00, step_cyc_reg};
            ADDR_TMO: rd_data = {8'h00, tmo_cyc_reg};
            ADDR_STAT: rd_data = sts;
            default: begin
                rd_data = 32'h00000000;
                reg_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (apb_setup) begin
            pready <= 1'b1;
            pslverr <= !reg_hit || (pwrite && paddr == ADDR_STAT);
            prdata <= pwrite ? 32'h00000000 : rd_data;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            step_cyc_reg <= STEP_CYC;
            tmo_cyc_reg <= TMO_SHORT_CYC;
        end else if (apb_wr) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_reg <= pwdata[3:0];
            end
            if (paddr == ADDR_STEP) begin
                step_cyc_reg <= pwdata[CW-1:0];
            end
            if (paddr == ADDR_TMO) begin
                tmo_cyc_reg <= pwdata[CW-1:0];
            end
        end
    end

    // checks
    sequence s_rail_up;
        state_reg == S_UP_WAIT && good_m[cur_ch] && step_reg != last_step && quiet;
    endsequence

    sequence s_pulse_start;
        $rose(fault_line_oe) ##0 supply_s[*8];
    endsequence

    a_lockout_all_off: assert property (!supply_s |=> en_reg == 5'h00 && !proc_reset_n)
        else $error("lockout did not force outputs and reset");
    a_ready_held_off: assert property (state_reg == S_READY && !start_ok |=> en_reg == 5'h00)
        else $error("output on before start conditions");
    a_start_first: assert property (state_reg == S_READY && start_ok
        |=> state_reg == S_UP_WAIT && $onehot(en_reg))
        else $error("power-up did not start with one output");
    a_step_waits: assert property (s_rail_up
        |=> state_reg == S_UP_DELAY && en_reg == $past(en_reg))
        else $error("next output released without step delay");
    a_rise_no_limit: assert property (state_reg == S_UP_WAIT && !good_m[cur_ch] && quiet
        |=> state_reg == S_UP_WAIT)
        else $error("left rail wait without rail good");
    a_drop_shutdown: assert property (rail_drop && supply_s
        |=> en_reg == 5'h00 && !proc_reset_n && fault_line_oe)
        else $error("rail drop did not shut down");
    a_fault_width: assert property (s_pulse_start |-> fault_line_oe[*8])
        else $error("fault pulse too short");
    a_reverse_one: assert property (state_reg == S_DOWN_REV && !drain_m[cur_ch]
        && step_reg != 3'h0 && supply_s && !ext_fault
        |=> $countones(en_reg) + 1 == $countones($past(en_reg)))
        else $error("reverse step did not turn one output off");
    a_enable_loss: assert property ((state_reg & (S_UP_WAIT | S_UP_DELAY | S_RUN)) != 6'h00
        && en_loss && !pd_req && supply_s && !ext_fault && !rail_drop
        |=> en_reg == 5'h00 && !proc_reset_n)
        else $error("enable loss did not power down at once");
    a_reset_hold: assert property (rst_hold && tmo_len > 24'h000008
        |=> (!proc_reset_n)[*8])
        else $error("reset released before timeout");
    a_pull_exclusive: assert property ((rail_enable & rail_discharge) == 5'h00
        && (rail_enable | rail_discharge) == 5'h1F)
        else $error("pulldown and output disagree");
    a_unplug_safe: assert property (drain_m != 5'h00 |=> !unplug_safe)
        else $error("unplug safe while a rail is charged");

endmodule

// file: tb/rss_rail_model.sv
// partner model: supply rails that ramp while gated on and drain through the pulldown
`timescale 1ns/1ps
module rss_rail_model (
    // clock
    input wire logic pclk,
    // gate control, pulldowns and injected rail collapse
    input wire logic [4:0] rail_enable,
    input wire logic [4:0] rail_discharge,
    input wire logic [4:0] rail_drop,
    // monitor outputs
    output logic [4:0] rail_good,
    output logic [4:0] rail_drain_sense
);
    // ramp level per rail, 0 = drained; a rail never drains unless its pulldown is on
    logic [4:0] lvl_reg [5] = '{default: 5'h00};
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 5; i++) begin
            if (rail_enable[i] && lvl_reg[i] != 5'h1F)
                lvl_reg[i] <= lvl_reg[i] + 5'h01;
            else if (!rail_enable[i] && rail_discharge[i] && lvl_reg[i] != 5'h00)
                lvl_reg[i] <= lvl_reg[i] - 5'h01;
        end
    end
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            rail_good[i] = lvl_reg[i] >= 5'h14 && !rail_drop[i];
            rail_drain_sense[i] = lvl_reg[i] != 5'h00;
        end
    end
endmodule

// file: tb/tb_rss_sequencer.sv
// testbench: sequencing orders, power-down modes, faults and registers
`timescale 1ns/1ps
module tb_rss_sequencer;
    import rss_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, fault_line_in, fault_line_out, fault_line_oe;
    logic supply_ok = 1'b0, enable_in = 1'b1, pd_req_n = 1'b1, hold_n = 1'b1, ext_n = 1'b1;
    logic [1:0] sel_a = 2'h0, sel_b = 2'h0, sel_c = 2'h0;
    logic [4:0] rail_good, drain, rail_enable, rail_discharge, rail_drop = 5'h00;
    logic proc_reset_n, unplug_safe;
    int n_mismatch = 0, samples_checked = 0, on_ord[5], off_ord[5], gap, tr, grp;
    int codes[5] = '{0, 5, 17, 23, 25};
    always #10 pclk = ~pclk;
    // wired fault line with pull-up
    assign fault_line_in = (fault_line_oe ? fault_line_out : 1'b1) & ext_n;
    rss_sequencer #(.RST_LONG_CYC(24'd200)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .internal_supply_ok(supply_ok),
        .enable_in(enable_in), .power_down_req_n(pd_req_n), .chain_hold_n(hold_n),
        .order_sel_a(sel_a), .order_sel_b(sel_b), .order_sel_c(sel_c), .rail_good(rail_good),
        .rail_drain_sense(drain), .fault_line_in(fault_line_in), .fault_line_out(fault_line_out),
        .fault_line_oe(fault_line_oe), .rail_enable(rail_enable),
        .rail_discharge(rail_discharge), .proc_reset_n(proc_reset_n), .unplug_safe(unplug_safe));
    rss_rail_model model_u (.pclk(pclk), .rail_enable(rail_enable),
        .rail_discharge(rail_discharge), .rail_drop(rail_drop), .rail_good(rail_good),
        .rail_drain_sense(drain));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // lexicographic permutation of 0..3 by index; codes past the table are ascending
    function automatic int perm_at(input int code, input int pos);
        int avail[$] = '{0, 1, 2, 3};
        int f[4] = '{6, 2, 1, 1};
        int q, r;
        r = (code >= 24) ? 0 : code;
        for (int p = 0; p <= pos; p++) begin
            q = r / f[p];
            r = r % f[p];
            perm_at = avail[q];
            avail.delete(q);
        end
    endfunction
    task automatic run_up(input int nch);
        int k, last;
        logic [4:0] seen;
        seen = 5'h00;
        k = 0;
        gap = 100000;
        last = 0;
        enable_in <= 1'b1;
        pd_req_n <= 1'b1;
        for (int t = 0; t < 8000 && k < nch; t++) begin
            @(posedge pclk);
            for (int i = 0; i < 5; i++) begin
                if (rail_enable[i] === 1'b1 && !seen[i]) begin
                    seen[i] = 1'b1;
                    if (k > 0 && t - last < gap) gap = t - last;
                    last = t;
                    on_ord[k++] = i;
                end
            end
        end
        chk(k, nch, "rails up");
        for (tr = 0; tr < 1000 && proc_reset_n !== 1'b1; tr++) @(posedge pclk);
    endtask
    task automatic run_off(input int exp_grp, input int nch);
        logic [4:0] prev;
        int k;
        k = 0;
        grp = 0;
        prev = rail_enable;
        for (int t = 0; t < 3000 && prev !== 5'h00; t++) begin
            @(posedge pclk);
            chk(rail_discharge, 5'(~rail_enable), "pulldown mirror");
            if (rail_enable !== prev) grp++;
            // reset must already be low once the first output has dropped
            if (grp > 0) chk(proc_reset_n, 1'b0, "reset in down");
            for (int i = 0; i < 5; i++) if (prev[i] && !rail_enable[i]) off_ord[k++] = i;
            prev = rail_enable;
        end
        chk(grp, exp_grp, "off groups");
        if (exp_grp > 1)
            for (int j = 0; j < nch; j++) chk(off_ord[j], on_ord[nch-1-j], "reverse");
        for (int t = 0; t < 500 && unplug_safe !== 1'b1; t++) @(posedge pclk);
        chk(unplug_safe, 1'b1, "unplug safe");
    endtask
    task automatic t_lockout_regs;
        chk({rail_enable, rail_discharge, proc_reset_n}, 11'h03E, "in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        wait_cyc(100);
        chk({rail_enable, rail_discharge, proc_reset_n}, 11'h03E, "lockout");
        enable_in <= 1'b0;
        supply_ok <= 1'b1;
        apb(1'b0, ADDR_STEP, 32'h0);
        chk(rd, 32'd500, "step reset");
        apb(1'b1, ADDR_STEP, 32'd20);
        apb(1'b1, ADDR_TMO, 32'd30);
        apb(1'b1, ADDR_CTRL, 32'h0000000C);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk({rd, err}, {32'h0000000C, 1'b0}, "ctrl rw");
        apb(1'b0, 12'h010, 32'h0);
        chk({rd, err}, {32'h0, 1'b1}, "unmapped");
        apb(1'b1, ADDR_STAT, 32'hFFFFFFFF);
        chk(err, 1'b1, "status ro");
        $display("test lockout_regs done");
    endtask
    task automatic t_order(input int code);
        sel_a <= 2'(code / 9);
        sel_b <= 2'((code / 3) % 3);
        sel_c <= 2'(code % 3);
        run_up(4);
        for (int p = 0; p < 4; p++) chk(on_ord[p], perm_at(code, p), "order");
        chk(gap >= 40, 1'b1, "step delay");
        chk(tr >= 30 && tr < 1000, 1'b1, "reset timeout");
        enable_in <= 1'b0;
        run_off(1, 4);
        $display("test order %0d done", code);
    endtask
    task automatic t_reverse;
        run_up(4);
        pd_req_n <= 1'b0;
        wait_cyc(20);
        enable_in <= 1'b0;
        run_off(4, 4);
        $display("test reverse done");
    endtask
    task automatic t_fault;
        run_up(4);
        rail_drop[on_ord[1]] <= 1'b1;
        for (int t = 0; t < 20 && fault_line_oe !== 1'b1; t++) @(posedge pclk);
        for (tr = 0; tr < 300 && fault_line_oe === 1'b1; tr++) @(posedge pclk);
        chk(tr, FAULT_CYC, "fault pulse");
        chk(rail_enable, 5'h00, "fault all off");
        run_off(0, 4);
        rail_drop <= 5'h00;
        run_up(4);
        ext_n <= 1'b0;
        wait_cyc(20);
        ext_n <= 1'b1;
        wait_cyc(80);
        chk(rail_enable, 5'h0F, "glitch ignored");
        ext_n <= 1'b0;
        run_off(1, 4);
        // keep the sequencer idle once the fault line is released
        enable_in <= 1'b0;
        ext_n <= 1'b1;
        $display("test fault done");
    endtask
    task automatic t_hold_five;
        apb(1'b1, ADDR_CTRL, 32'h00000003);
        run_up(5);
        for (int p = 0; p < 5; p++) chk(on_ord[p], p, "five order");
        chk(gap >= 500 && tr >= 200, 1'b1, "default step, fixed timeout");
        hold_n <= 1'b0;
        wait_cyc(4);
        enable_in <= 1'b0;
        wait_cyc(120);
        chk(rail_enable, 5'h1F, "hold keeps rails");
        enable_in <= 1'b1;
        wait_cyc(4);
        hold_n <= 1'b1;
        pd_req_n <= 1'b0;
        run_off(5, 5);
        $display("test hold_five done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        wait_cyc(5);
        t_lockout_regs();
        foreach (codes[j]) t_order(codes[j]);
        t_reverse();
        t_fault();
        t_hold_five();
        wrap_up();
    end
    initial begin
        wait_cyc(90000);
        n_mismatch++;
        wrap_up();
    end
endmodule
